// ==== dcd_core.sv ====
// command, clock-enable and bank state logic of the dram device
`timescale 1ns/1ps
module dcd_core
    import dcd_pkg::*;
#(
    parameter int DATA_BYTES = 2   // byte lanes of one beat
)(
    // clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    reset,
    // command and address pins
    input  wire dcd_pins_t               pins,
    input  wire logic                    odt,
    // write data beat with mask
    input  wire logic                    wdata_valid,
    input  wire logic [DATA_BYTES*8-1:0] wdata,
    input  wire logic [DATA_BYTES-1:0]   dm,
    // decoded command, one cycle pulse
    output dcd_cmd_t                     cmd,
    output logic                         cmd_valid,
    output logic [BA_W-1:0]              cmd_ba,
    output logic [ADDR_W-1:0]            cmd_addr,
    // state outputs
    output dcd_pstate_t                  pstate,
    output logic [NBANK-1:0]             bank_open,
    output logic                         burst_busy,
    output logic                         odt_active,
    output logic                         illegal,
    // masked write to the array
    output logic [DATA_BYTES*8-1:0]      array_wdata,
    output logic [DATA_BYTES-1:0]        array_wbe,
    output logic                         array_we
);
    // whole module state
    typedef struct packed {
        logic                    cke;       // cke at previous edge
        dcd_pstate_t             ps;        // power state
        logic [NBANK-1:0]        open;      // open row per bank
        logic [BCNT_W-1:0]       bcnt;      // burst beats left
        logic                    wr;        // burst is a write
        logic                    ap;        // auto precharge pending
        logic [BA_W-1:0]         ap_ba;     // bank to close at end
        dcd_cmd_t                cmd;       // last command
        logic                    vld;       // command pulse
        logic [BA_W-1:0]         ba;        // last bank
        logic [ADDR_W-1:0]       addr;      // last address
        logic                    ill;       // illegal sticky
        logic [DATA_BYTES*8-1:0] wd;        // array data
        logic [DATA_BYTES-1:0]   be;        // array byte enables
        logic                    we;        // array write
    } dcd_state_t;

    dcd_state_t s_q;  // registered state
    dcd_state_t s_d;  // next state
    dcd_dec_t   dec;  // decoded command

    // one-hot bank select
    function automatic logic [NBANK-1:0] bank_sel(
        input logic [BA_W-1:0] b);
        bank_sel = NBANK'(1) << b;
    endfunction : bank_sel

    // decoder; odt is never an input to it
    dcd_cmd_decode u_dec (
        .pins     (pins),
        .cke_prev (s_q.cke),
        .dec      (dec)
    );

    // next state
    always_comb begin
        s_d     = s_q;
        s_d.cke = pins.cke;
        s_d.vld = 1'b0;
        s_d.we  = 1'b0;
        // burst of four counts down to its end unless a new read or write restarts it
        if (s_q.bcnt != '0) s_d.bcnt = s_q.bcnt - BCNT_W'(1);
        // write beats stored by mask, only inside a write burst
        s_d.we = wdata_valid && (s_q.bcnt != '0) && s_q.wr;
        s_d.wd = wdata;
        s_d.be = ~dm;
        case (dec.cmd)
            CMD_HOLD: ;  // keep power state
            CMD_EXIT: begin
                // exit restores same bank state; open kept
                // taken at the first edge that sees cke high again
                s_d.ps = PS_ON;
            end
            CMD_PDE: begin
                // power-down kind from bank state
                s_d.ps = (s_q.open != '0) ? PS_ACT_PD : PS_PRE_PD;
            end
            CMD_SREF: begin
                if (s_q.open == '0) s_d.ps = PS_SREF;
                else s_d.ill = 1'b1;
            end
            CMD_ACT:  s_d.open = s_q.open | bank_sel(dec.ba);
            CMD_PRE:  s_d.open = s_q.open & ~bank_sel(dec.ba);
            CMD_PREA: s_d.open = '0;
            CMD_RD, CMD_RDA, CMD_WR, CMD_WRA: begin
                // restart the burst and note its kind and bank
                s_d.bcnt  = BCNT_W'(BURST);
                s_d.wr    = (dec.cmd == CMD_WR || dec.cmd == CMD_WRA);
                s_d.ap    = (dec.cmd == CMD_RDA || dec.cmd == CMD_WRA);
                s_d.ap_ba = dec.ba;
            end
            CMD_ILLEGAL: s_d.ill = 1'b1;
            default: ;
        endcase
        // auto precharge closes its own bank on burst end, even when
        // later commands other than a read or write have replaced cmd and ba
        if (s_q.ap && s_q.bcnt == BCNT_W'(1)) begin
            s_d.open = s_d.open & ~bank_sel(s_q.ap_ba);
        end
        // the pending close is spent once no burst follows
        if (s_d.bcnt == '0) begin
            s_d.ap = 1'b0;
        end
        if (dec.cmd != CMD_HOLD && dec.cmd != CMD_DESEL
            && dec.cmd != CMD_NOP && dec.cmd != CMD_EXIT) begin
            s_d.vld  = 1'b1;
            s_d.cmd  = dec.cmd;
            s_d.ba   = dec.ba;
            s_d.addr = dec.addr;
        end
    end

    // state register; reset takes the previous cke as high so the first
    // edge after release decodes the pins as a normal command
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s_q     <= '0;
            s_q.cke <= 1'b1;
            s_q.ps  <= PS_ON;
            s_q.cmd <= CMD_NOP;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs
    assign cmd         = s_q.cmd;
    assign cmd_valid   = s_q.vld;
    assign cmd_ba      = s_q.ba;
    assign cmd_addr    = s_q.addr;
    assign pstate      = s_q.ps;
    assign bank_open   = s_q.open;
    assign burst_busy  = (s_q.bcnt != '0);
    assign illegal     = s_q.ill;
    // termination unavailable in self refresh
    assign odt_active  = odt && (s_q.ps != PS_SREF);
    assign array_wdata = s_q.wd;
    assign array_wbe   = s_q.be;
    assign array_we    = s_q.we;

    // exit from self refresh needs no extra edge
    chk_sref_exit: assert property (@(posedge core_clk) disable iff (reset)
        (s_q.ps == PS_SREF && pins.cke) |=> s_q.ps == PS_ON)
        else $error("self refresh exit not taken");
    chk_pd_kind: assert property (@(posedge core_clk) disable iff (reset)
        (s_q.ps == PS_ON && s_q.cke && !pins.cke && dec.cmd == CMD_PDE)
        |=> s_q.ps == ((s_q.open != '0) ? PS_ACT_PD : PS_PRE_PD))
        else $error("wrong power-down kind");
    chk_pd_hold: assert property (@(posedge core_clk) disable iff (reset)
        (!s_q.cke && !pins.cke) |=> $stable(s_q.ps) && $stable(s_q.open))
        else $error("state changed while cke low");
    chk_burst_len: assert property (@(posedge core_clk) disable iff (reset)
        (dec.cmd == CMD_RD) |=> burst_busy [*4] ##1 !burst_busy)
        else $error("burst length wrong");
    chk_act_open: assert property (@(posedge core_clk) disable iff (reset)
        (dec.cmd == CMD_ACT) |=> bank_open[$past(pins.ba)])
        else $error("activate did not open bank");
    chk_prea_idle: assert property (@(posedge core_clk) disable iff (reset)
        (dec.cmd == CMD_PREA && !burst_busy) |=> bank_open == '0)
        else $error("precharge all left bank open");
    chk_desel_none: assert property (@(posedge core_clk) disable iff (reset)
        (pins.cs_n && pins.cke && s_q.cke) |=> !cmd_valid)
        else $error("command accepted while deselected");
    chk_mask_write: assert property (@(posedge core_clk) disable iff (reset)
        (wdata_valid && burst_busy && s_q.wr) |=> array_we
        && array_wbe == ~$past(dm))
        else $error("mask not applied");
    chk_pd_restore: assert property (@(posedge core_clk) disable iff (reset)
        (s_q.ps == PS_ACT_PD && pins.cke) |=> s_q.ps == PS_ON
        && $stable(bank_open))
        else $error("bank state lost on exit");
    chk_mrs_dec: assert property (@(posedge core_clk) disable iff (reset)
        (s_q.cke && pins.cke && !pins.cs_n && !pins.ras_n && !pins.cas_n
         && !pins.we_n) |=> cmd == CMD_MRS && cmd_valid)
        else $error("mode register set not decoded");
    // a read burst never writes the array, whatever wdata_valid does
    chk_read_nowrite: assert property (@(posedge core_clk)
        disable iff (reset) (burst_busy && !s_q.wr) |=> !array_we)
        else $error("array written during a read burst");
    // the auto precharge bank is closed once its burst is over
    chk_ap_close: assert property (@(posedge core_clk)
        disable iff (reset) (s_q.ap && s_q.bcnt == BCNT_W'(1)
        && dec.cmd != CMD_ACT) |=> !bank_open[$past(s_q.ap_ba)])
        else $error("auto precharge left bank open");
    // an unlisted strobe pattern with cke high raises the flag
    chk_illegal_set: assert property (@(posedge core_clk)
        disable iff (reset) (s_q.cke && pins.cke && !pins.cs_n
        && pins.ras_n && pins.cas_n && !pins.we_n) |=> illegal)
        else $error("unlisted command not flagged");
    // a nop with cke high leaves no command pulse
    chk_nop_quiet: assert property (@(posedge core_clk)
        disable iff (reset) (s_q.cke && pins.cke && !pins.cs_n
        && pins.ras_n && pins.cas_n && pins.we_n) |=> !cmd_valid)
        else $error("nop produced a command pulse");
    // a write burst runs its four beats to the end
    chk_wr_len: assert property (@(posedge core_clk)
        disable iff (reset) (dec.cmd == CMD_WR || dec.cmd == CMD_WRA)
        |=> burst_busy [*4] ##1 !burst_busy)
        else $error("write burst length wrong");

    cov_sref: cover property (@(posedge core_clk) disable iff (reset)
        s_q.ps == PS_SREF ##[1:20] s_q.ps == PS_ON);
    cov_act_pd: cover property (@(posedge core_clk) disable iff (reset)
        s_q.ps == PS_ACT_PD);
    cov_wra: cover property (@(posedge core_clk) disable iff (reset)
        dec.cmd == CMD_WRA);
    cov_illegal: cover property (@(posedge core_clk) disable iff (reset)
        $rose(illegal));
    cov_pre_pd: cover property (@(posedge core_clk) disable iff (reset)
        s_q.ps == PS_PRE_PD);
endmodule : dcd_core

// ==== dcd_pkg.sv ====
// package with command codes, states and carrier structs for the decoder
// Contract
// - command taken from pin levels at edge
// - mode register set: all strobes low
// - activate opens row, precharge closes banks
// - read/write column, a10 auto precharge
// - refresh, self refresh entry when idle
// - burst of four always completes; here a new read or write restarts it
// - cke drop enters active or precharge power-down
// - cke low twice holds state, ignores commands; here a running burst counts down and auto precharge still closes its bank
// - self refresh exit asynchronous; here taken at the first core_clk edge that sees cke high
// - termination input ignored by decoding
// - cke high twice: command must be legal
// - mask low writes byte, high keeps
// - chip select high accepts no command; here cke falling with chip select high still decodes power-down entry
package dcd_pkg;
    localparam int NBANK    = 4;   // internal banks
    localparam int BA_W     = 2;   // bank address width
    localparam int ADDR_W   = 13;  // address width
    localparam int AP_BIT   = 10;  // auto precharge / all banks bit
    localparam int BURST    = 4;   // burst length
    localparam int BCNT_W   = 3;   // burst counter width
    // command encodings {ras_n, cas_n, we_n}
    localparam logic [2:0] ENC_MRS = 3'h0;
    localparam logic [2:0] ENC_REF = 3'h1;
    localparam logic [2:0] ENC_PRE = 3'h2;
    localparam logic [2:0] ENC_ACT = 3'h3;
    localparam logic [2:0] ENC_WR  = 3'h4;
    localparam logic [2:0] ENC_RD  = 3'h5;
    localparam logic [2:0] ENC_NOP = 3'h7;

    // decoded commands
    typedef enum logic [3:0] {
        CMD_DESEL, CMD_NOP, CMD_MRS, CMD_REF, CMD_SREF, CMD_PRE,
        CMD_PREA, CMD_ACT, CMD_WR, CMD_WRA, CMD_RD, CMD_RDA,
        CMD_PDE, CMD_EXIT, CMD_HOLD, CMD_ILLEGAL
    } dcd_cmd_t;

    // power state of the device
    typedef enum logic [1:0] {
        PS_ON, PS_ACT_PD, PS_PRE_PD, PS_SREF
    } dcd_pstate_t;

    // command pins sampled at the rising edge
    typedef struct packed {
        logic              cke;
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic [BA_W-1:0]   ba;
        logic [ADDR_W-1:0] addr;
    } dcd_pins_t;

    // decoded command with its operands
    typedef struct packed {
        dcd_cmd_t          cmd;
        logic [BA_W-1:0]   ba;
        logic [ADDR_W-1:0] addr;
    } dcd_dec_t;
endpackage : dcd_pkg

// ==== dcd_cmd_decode.sv ====
// combinational command decoder from pins and previous clock enable
`timescale 1ns/1ps
module dcd_cmd_decode
    import dcd_pkg::*;
(
    // sampled pins
    input  wire dcd_pins_t pins,
    input  wire logic      cke_prev,
    // decoded command
    output dcd_dec_t       dec
);
    logic [2:0] enc;  // strobe triple

    // decode purely from pin and cke levels
    always_comb begin
        enc      = {pins.ras_n, pins.cas_n, pins.we_n};
        dec.ba   = pins.ba;
        dec.addr = pins.addr;
        dec.cmd  = CMD_ILLEGAL;
        if (!cke_prev) begin
            // cke low twice ignores command pins
            dec.cmd = pins.cke ? CMD_EXIT : CMD_HOLD;
        end else if (pins.cs_n) begin
            // chip select high: no new command, except power-down entry when cke falls
            dec.cmd = pins.cke ? CMD_DESEL : CMD_PDE;
        end else if (!pins.cke) begin
            // cke falling with nop or refresh
            if (enc == ENC_NOP) dec.cmd = CMD_PDE;
            else if (enc == ENC_REF) dec.cmd = CMD_SREF;
        end else begin
            case (enc)
                ENC_MRS: dec.cmd = CMD_MRS;
                ENC_REF: dec.cmd = CMD_REF;
                ENC_PRE: dec.cmd = pins.addr[AP_BIT] ? CMD_PREA
                                                     : CMD_PRE;
                ENC_ACT: dec.cmd = CMD_ACT;
                ENC_WR:  dec.cmd = pins.addr[AP_BIT] ? CMD_WRA
                                                     : CMD_WR;
                ENC_RD:  dec.cmd = pins.addr[AP_BIT] ? CMD_RDA
                                                     : CMD_RD;
                ENC_NOP: dec.cmd = CMD_NOP;
                default: dec.cmd = CMD_ILLEGAL;
            endcase
        end
    end
endmodule : dcd_cmd_decode

// ==== dcd_ctl_model.sv ====
// controller model that drives the command pins and write data
`timescale 1ns/1ps
module dcd_ctl_model
    import dcd_pkg::*;
(
    // clock
    input  wire logic   core_clk,
    // command pins and write data
    output dcd_pins_t   pins,
    output logic        odt,
    output logic        wdata_valid,
    output logic [15:0] wdata,
    output logic [1:0]  dm
);
    // every pin starts at a defined level, odt included
    initial begin
        pins        = {1'b1, 1'b1, ENC_NOP, 2'h0, 13'h0};
        odt         = 1'b0;
        wdata_valid = 1'b0;
        wdata       = 16'h0000;
        dm          = 2'h0;
    end
    // one command edge; idle data lines toggle so stale data never matches
    task cmd(input logic c, input logic cs, input logic [2:0] e,
             input logic [1:0] b, input logic [12:0] a);
        @(posedge core_clk);
        #1;
        pins        = {c, cs, e, b, a};
        wdata_valid = 1'b0;
        wdata       = ~wdata;
    endtask : cmd
    // one write beat under a nop
    task beat(input logic [15:0] d, input logic [1:0] m);
        @(posedge core_clk);
        #1;
        pins        = {1'b1, 1'b0, ENC_NOP, 2'h0, 13'h0};
        wdata_valid = 1'b1;
        wdata       = d;
        dm          = m;
    endtask : beat
    // termination request, always a defined level
    task set_odt(input logic v);
        odt = v;
    endtask : set_odt
endmodule : dcd_ctl_model

// ==== tb_top.sv ====
// self-checking bench for the dram command and clock-enable logic
`timescale 1ns/1ps
module tb_top
    import dcd_pkg::*;
;
    logic        core_clk;
    logic        reset;
    dcd_pins_t   pins;
    logic        odt, wdata_valid, cmd_valid, burst_busy;
    logic        odt_active, illegal, array_we;
    logic [15:0] wdata, array_wdata;
    logic [1:0]  dm, cmd_ba, array_wbe;
    logic [12:0] cmd_addr;
    logic [3:0]  bank_open;
    dcd_cmd_t    cmd;
    dcd_pstate_t pstate;
    int          bad_count, total_checks, cycles;
    logic [15:0] wd [4] = '{16'h1234, 16'habcd, 16'h5a5a, 16'h0ff0};
    logic [1:0]  wm [4] = '{2'h1, 2'h0, 2'h2, 2'h3};

    dcd_ctl_model ctl (.core_clk(core_clk), .pins(pins), .odt(odt),
        .wdata_valid(wdata_valid), .wdata(wdata), .dm(dm));
    dcd_core #(.DATA_BYTES(2)) DUT (.core_clk(core_clk), .reset(reset),
        .pins(pins), .odt(odt), .wdata_valid(wdata_valid),
        .wdata(wdata), .dm(dm), .cmd(cmd), .cmd_valid(cmd_valid),
        .cmd_ba(cmd_ba), .cmd_addr(cmd_addr), .pstate(pstate),
        .bank_open(bank_open), .burst_busy(burst_busy),
        .odt_active(odt_active), .illegal(illegal),
        .array_wdata(array_wdata), .array_wbe(array_wbe),
        .array_we(array_we));

    // 125 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 1000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    // value compare
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // command pulse compare
    task chk_cmd(input dcd_cmd_t e);
        chk("cmd_valid", 16'h1, 16'(cmd_valid));
        chk("cmd", 16'(e), 16'(cmd));
    endtask : chk_cmd
    task nop(input logic c);
        ctl.cmd(c, 1'b0, ENC_NOP, 2'h0, 13'h0);
    endtask : nop

    initial begin
        reset = 1'b1;
        repeat (16) @(posedge core_clk);
        #1 reset = 1'b0;
        chk("pstate", 16'(PS_ON), 16'(pstate));
        chk("bank_open", 16'h0, 16'(bank_open));
        chk("cmd_valid", 16'h0, 16'(cmd_valid));
        // activate bank 1, then write with auto precharge and masks
        ctl.cmd(1'b1, 1'b0, ENC_ACT, 2'h1, 13'h0123);
        ctl.cmd(1'b1, 1'b0, ENC_WR, 2'h1, 13'h0404);
        chk_cmd(CMD_ACT);
        chk("bank_open", 16'h2, 16'(bank_open));
        for (int i = 0; i < 4; i++) begin
            ctl.beat(wd[i], wm[i]);
            if (i == 0) chk_cmd(CMD_WRA);
            if (i == 0) chk("burst_busy", 16'h1, 16'(burst_busy));
            if (i > 0) chk("wbe", {14'h0, ~wm[i-1]}, 16'(array_wbe));
            if (i > 0) chk("array_we", 16'h1, 16'(array_we));
            if (i > 0) chk("wdata", wd[i-1], array_wdata);
        end
        nop(1'b1);
        chk("wbe", {14'h0, ~wm[3]}, 16'(array_wbe));
        chk("wdata", wd[3], array_wdata);
        nop(1'b1);
        chk("bank_open", 16'h0, 16'(bank_open));
        // activate bank 2, then a deselect that looks like an activate
        ctl.cmd(1'b1, 1'b0, ENC_ACT, 2'h2, 13'h0);
        ctl.cmd(1'b1, 1'b1, ENC_ACT, 2'h3, 13'h0);
        chk("cmd_ba", 16'h2, 16'(cmd_ba));
        nop(1'b1);
        chk("cmd_valid", 16'h0, 16'(cmd_valid));
        chk("bank_open", 16'h4, 16'(bank_open));
        // active power-down, junk on the pins while cke stays low
        nop(1'b0);
        ctl.cmd(1'b0, 1'b0, ENC_ACT, 2'h0, 13'h0);
        ctl.cmd(1'b0, 1'b0, ENC_ACT, 2'h0, 13'h0);
        chk("pstate", 16'(PS_ACT_PD), 16'(pstate));
        nop(1'b1);
        chk("bank_open", 16'h4, 16'(bank_open));
        nop(1'b1);
        chk("pstate", 16'(PS_ON), 16'(pstate));
        chk("bank_open", 16'h4, 16'(bank_open));
        // single bank close, then close all
        ctl.cmd(1'b1, 1'b0, ENC_PRE, 2'h2, 13'h0);
        ctl.cmd(1'b1, 1'b0, ENC_ACT, 2'h0, 13'h0);
        chk_cmd(CMD_PRE);
        ctl.cmd(1'b1, 1'b0, ENC_ACT, 2'h3, 13'h0);
        ctl.cmd(1'b1, 1'b0, ENC_PRE, 2'h0, 13'h0400);
        chk("bank_open", 16'h9, 16'(bank_open));
        nop(1'b1);
        chk_cmd(CMD_PREA);
        chk("bank_open", 16'h0, 16'(bank_open));
        // precharge power-down from idle
        ctl.cmd(1'b0, 1'b1, ENC_NOP, 2'h0, 13'h0);
        nop(1'b0);
        nop(1'b0);
        chk("pstate", 16'(PS_PRE_PD), 16'(pstate));
        repeat (3) nop(1'b1);
        chk("pstate", 16'(PS_ON), 16'(pstate));
        // mode register load and refresh
        ctl.cmd(1'b1, 1'b0, ENC_MRS, 2'h2, 13'h00a5);
        ctl.cmd(1'b1, 1'b0, ENC_REF, 2'h0, 13'h0);
        chk_cmd(CMD_MRS);
        chk("cmd_ba", 16'h2, 16'(cmd_ba));
        chk("cmd_addr", 16'h00a5, 16'(cmd_addr));
        nop(1'b1);
        chk_cmd(CMD_REF);
        // self refresh with termination requested
        ctl.cmd(1'b0, 1'b0, ENC_REF, 2'h0, 13'h0);
        ctl.set_odt(1'b1);
        nop(1'b0);
        nop(1'b0);
        chk("pstate", 16'(PS_SREF), 16'(pstate));
        chk("odt_active", 16'h0, 16'(odt_active));
        nop(1'b1);
        nop(1'b1);
        chk("pstate", 16'(PS_ON), 16'(pstate));
        chk("odt_active", 16'h1, 16'(odt_active));
        repeat (200) nop(1'b1);
        // reads with a9 set and with auto precharge
        ctl.cmd(1'b1, 1'b0, ENC_ACT, 2'h0, 13'h0);
        ctl.cmd(1'b1, 1'b0, ENC_RD, 2'h0, 13'h0200);
        nop(1'b1);
        chk_cmd(CMD_RD);
        repeat (3) nop(1'b1);
        ctl.cmd(1'b1, 1'b0, ENC_RD, 2'h0, 13'h0400);
        nop(1'b1);
        chk_cmd(CMD_RDA);
        repeat (5) nop(1'b1);
        chk("bank_open", 16'h0, 16'(bank_open));
        chk("burst_busy", 16'h0, 16'(burst_busy));
        // plain write to bank 3, then a read with auto precharge that a
        // bank 1 activate overtakes; data beats during the read are junk
        ctl.cmd(1'b1, 1'b0, ENC_ACT, 2'h3, 13'h0);
        ctl.cmd(1'b1, 1'b0, ENC_WR, 2'h3, 13'h0008);
        nop(1'b1);
        chk_cmd(CMD_WR);
        chk("bank_open", 16'h8, 16'(bank_open));
        repeat (3) nop(1'b1);
        ctl.cmd(1'b1, 1'b0, ENC_RD, 2'h3, 13'h0400);
        ctl.cmd(1'b1, 1'b0, ENC_ACT, 2'h1, 13'h0);
        nop(1'b1);
        chk("bank_open", 16'ha, 16'(bank_open));
        repeat (3) ctl.beat(16'hffff, 2'h0);
        chk("array_we", 16'h0, 16'(array_we));
        chk("bank_open", 16'h2, 16'(bank_open));
        chk("illegal", 16'h0, 16'(illegal));
        // unlisted encoding with cke high
        ctl.cmd(1'b1, 1'b0, 3'h6, 2'h0, 13'h0);
        nop(1'b1);
        chk("illegal", 16'h1, 16'(illegal));
        report_and_stop();
    end
endmodule : tb_top
